//--- include/sac_consts.svh
// Timing counts and field widths shared by both ends of the converter link.
// Assumes a 125 MHz system clock on both ends.
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
`define SAC_CLK_PERIOD_PS   8000
`define SAC_PWRUP_TIME_NS   1000
`define SAC_PWRUP_CYCLES    ((`SAC_PWRUP_TIME_NS * 1000 + `SAC_CLK_PERIOD_PS - 1) / `SAC_CLK_PERIOD_PS)
`define SAC_CONV_TIME_NS    2300
`define SAC_CONV_CYCLES     ((`SAC_CONV_TIME_NS * 1000 + `SAC_CLK_PERIOD_PS - 1) / `SAC_CLK_PERIOD_PS)
`define SAC_READ_GAP_NS     100
`define SAC_READ_GAP_CYCLES ((`SAC_READ_GAP_NS * 1000 + `SAC_CLK_PERIOD_PS - 1) / `SAC_CLK_PERIOD_PS)
`define SAC_READ_WAIT_CYCLES 4
`define SAC_RESULT_W        10
`define SAC_BUS_W           8
`define SAC_CODE_STEPS      1024
`define SAC_CNT_W           12
`endif

//--- include/sac_pkg.sv
// Types shared by both ends of the converter link.
// Assumes sac_consts.svh is on the include path.
`include "sac_consts.svh"
package sac_pkg;
  typedef logic [`SAC_RESULT_W-1:0] sac_result_t;
  typedef logic [`SAC_BUS_W-1:0]    sac_byte_t;
  typedef logic [`SAC_CNT_W-1:0]    sac_count_t;
  typedef enum logic [1:0] {SAC_POWERED_DOWN, SAC_POWERING_UP, SAC_IDLE, SAC_CONVERTING} sac_state_e;
endpackage

//--- include/sac_if.sv
// Parallel converter link: start strobe, busy flag, chip select, read strobe, data bus.
// Assumes the testbench resolves the data bus from the enable.
`timescale 1ns/10ps
interface sac_if;
  logic             conversion_start_n;
  logic             busy;
  logic             chip_select_n;
  logic             read_strobe_n;
  logic [7:0]       data_out;
  logic             data_oe;
  modport device (input conversion_start_n, chip_select_n, read_strobe_n,
                  output busy, data_out, data_oe);
  modport host   (output conversion_start_n, chip_select_n, read_strobe_n,
                  input busy, data_out, data_oe);
endinterface

//--- verilog/sac_device.sv
// Converter end: power-up pulse, gated start, busy timing, mode choice and byte reads.
// Assumes link inputs are synchronous to CLOCK_IN and the analog code arrives on SAMPLE_CODE_IN.
// How it works
// [RULE1] Result is straight binary, step reference over 1024.
// [RULE2] Starts powered down after reset.
// [RULE3] Start rising edge fires a 1 us pulse.
// [RULE4] Gated start is start OR pulse.
// [RULE5] Later falling edge of both starts conversion.
// [RULE6] Busy stays high throughout conversion.
// [RULE7] End: track, busy low, latch result.
// [RULE8] Start high at end: stay powered.
// [RULE9] Start low before end: power down.
// [RULE10] Reads still work while powered down.
// [RULE11] Host spaces starts by conversion plus read.
// [RULE12] Drive bus only with select and read low.
// [RULE13] First read upper byte, second low bits.
// [RULE14] Further reads keep alternating.
// [RULE15] Busy rising resets read order.
// [RULE16] Host never reads while busy.
// [RULE17] Host ends reads 100 ns before start.
// [RULE18] Host holds start low at power-up.
// [RULE19] Host keeps start pulse short for power.
// [RULE20] Host uses fast mode above 100 kSPS.
// [RULE21] Busy lasts a fixed counted duration.
// [RULE22] Bus released when select or read high.
// [RULE23] Acquisition runs from conversion end to start.
`timescale 1ns/10ps
`include "sac_consts.svh"
module sac_device
  import sac_pkg::*;
#(
  parameter int CONV_CYCLES = `SAC_CONV_CYCLES
) (
  // Clock and reset.
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_IN,
  // Analog side, already digitised.
  input  wire sac_result_t SAMPLE_CODE_IN,
  // Link.
  sac_if.device            LINK,
  // Status.
  output logic             POWERED_OUT,
  output logic             TRACKING_OUT,
  output logic             FAST_MODE_OUT
);
  localparam sac_count_t PWRUP_CYCLES = sac_count_t'(`SAC_PWRUP_CYCLES);
  localparam sac_count_t CONV_LEN     = sac_count_t'(CONV_CYCLES);

  sac_state_e  state;
  sac_count_t  pulse_cnt;
  sac_count_t  conv_cnt;
  logic        start_q;
  logic        pulse;
  logic        gated_q;
  logic        read_q;
  logic        low_half;
  sac_result_t result;
  logic        busy;
  logic        gated;
  logic        start_rise;
  logic        gated_fall;
  logic        read_end;
  logic        conv_done;
  logic        conv_start;
  logic        read_sel;

  // Select decode is shared by the edge detector, the read order and the bus enable.
  function automatic logic sac_read_sel(input logic cs_n, input logic rd_n);
    return ~cs_n & ~rd_n;
  endfunction

  assign gated      = LINK.conversion_start_n | pulse; // [RULE4]
  assign start_rise = LINK.conversion_start_n & ~start_q;
  assign gated_fall = gated_q & ~gated; // [RULE5]
  assign read_sel   = sac_read_sel(LINK.chip_select_n, LINK.read_strobe_n);
  assign read_end   = read_q & ~read_sel;
  // A pulse that ends while powered down must not look like a conversion start.
  assign conv_start = gated_fall && (state == SAC_POWERING_UP || state == SAC_IDLE); // [RULE5]
  assign conv_done  = (state == SAC_CONVERTING) && (conv_cnt == CONV_LEN - 12'h001); // [RULE21]

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      start_q <= 1'b0;
      gated_q <= 1'b0;
      read_q  <= 1'b0;
    end else begin
      start_q <= LINK.conversion_start_n;
      gated_q <= gated;
      read_q  <= read_sel;
    end
  end

  // The pulse retriggers on every rising start edge, so a fast host never loses power-up time.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      pulse     <= 1'b0;
      pulse_cnt <= '0;
    end else if (start_rise) begin
      pulse     <= 1'b1; // [RULE3]
      pulse_cnt <= PWRUP_CYCLES - 12'h001;
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 12'h001;
    end else begin
      pulse     <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state <= SAC_POWERED_DOWN; // [RULE2]
    end else begin
      case (state)
        SAC_POWERED_DOWN: begin
          if (start_rise) begin
            state <= SAC_POWERING_UP; // [RULE3]
          end
        end
        SAC_POWERING_UP, SAC_IDLE: begin
          if (gated_fall) begin
            state <= SAC_CONVERTING; // [RULE5]
          end
        end
        SAC_CONVERTING: begin
          if (conv_done) begin
            state <= LINK.conversion_start_n ? SAC_IDLE : SAC_POWERED_DOWN; // [RULE8] [RULE9]
          end
        end
        default: begin
          state <= SAC_POWERED_DOWN;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      conv_cnt <= '0;
    end else if (state == SAC_CONVERTING) begin
      conv_cnt <= conv_cnt + 12'h001; // [RULE21]
    end else begin
      conv_cnt <= '0;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      busy <= 1'b0;
    end else begin
      busy <= (state == SAC_CONVERTING) ? ~conv_done : conv_start; // [RULE6] [RULE7]
    end
  end

  // Tracking drops with the start so the sample is held through the whole conversion.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      TRACKING_OUT <= 1'b1;
    end else begin
      TRACKING_OUT <= (state == SAC_CONVERTING) ? conv_done : ~conv_start; // [RULE23]
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      FAST_MODE_OUT <= 1'b0;
    end else if (conv_done) begin
      FAST_MODE_OUT <= LINK.conversion_start_n; // [RULE8]
    end
  end

  // A start rise lights the flag at once; the pulse then covers the power-up time.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      POWERED_OUT <= 1'b0;
    end else begin
      POWERED_OUT <= (state == SAC_CONVERTING) ? (~conv_done | LINK.conversion_start_n)
                                               : ((state != SAC_POWERED_DOWN) | start_rise);
    end
  end

  // Code is taken as straight binary; the analog front end supplies it already scaled.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      result <= '0;
    end else if (conv_done) begin
      result <= SAMPLE_CODE_IN; // [RULE1] [RULE7]
    end
  end

  // Read order advances at the end of each strobe and restarts when a conversion begins.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      low_half <= 1'b0;
    end else if (conv_start) begin
      low_half <= 1'b0; // [RULE15]
    end else if (read_end) begin
      low_half <= ~low_half; // [RULE14]
    end
  end

  // Powered-down state does not gate the port, so reads keep working.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      LINK.data_oe  <= 1'b0;
      LINK.data_out <= 8'h00;
    end else begin
      LINK.data_oe  <= read_sel; // [RULE12] [RULE22] [RULE10]
      LINK.data_out <= low_half ? {result[1:0], 6'h00} : result[9:2]; // [RULE13]
    end
  end

  assign LINK.busy = busy;
endmodule

//--- verilog/sac_host.sv
// Host end: issues a start pulse, waits for busy to fall, then reads one or two bytes.
// Assumes the device answers on the same clock; the byte is taken after a fixed wait, without checking the data enable.
`timescale 1ns/10ps
`include "sac_consts.svh"
module sac_host
  import sac_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_IN,
  // User request.
  input  wire logic        REQ_IN,
  input  wire logic        AUTO_POWER_DOWN_IN,
  input  wire logic        BYTE_ONLY_IN,
  // Link.
  sac_if.host              LINK,
  // User answer.
  output logic             DONE_OUT,
  output sac_result_t      RESULT_OUT,
  output logic             READY_OUT
);
  typedef enum logic [2:0] {H_IDLE, H_HIGH, H_WAIT, H_RD1, H_SEP, H_RD2, H_GAP} sac_host_e;
  localparam sac_count_t PULSE_LEN = sac_count_t'(`SAC_PWRUP_CYCLES);
  localparam sac_count_t GAP_LEN   = sac_count_t'(`SAC_READ_GAP_CYCLES);
  localparam sac_count_t RD_LEN    = sac_count_t'(`SAC_READ_WAIT_CYCLES);

  sac_host_e   state;
  sac_count_t  cnt;
  logic        busy_q;
  logic        apd;
  sac_byte_t   upper;

  // Start held low out of reset so the device sees a clean power-up.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state                   <= H_IDLE;
      cnt                     <= '0;
      busy_q                  <= 1'b0;
      apd                     <= 1'b0;
      upper                   <= 8'h00;
      LINK.conversion_start_n <= 1'b0; // [RULE18]
      LINK.chip_select_n      <= 1'b1;
      LINK.read_strobe_n      <= 1'b1;
      DONE_OUT                <= 1'b0;
      RESULT_OUT              <= '0;
      READY_OUT               <= 1'b0;
    end else begin
      busy_q   <= LINK.busy;
      DONE_OUT <= 1'b0;
      case (state)
        H_IDLE: begin
          READY_OUT <= ~REQ_IN;
          if (REQ_IN) begin
            apd                     <= AUTO_POWER_DOWN_IN; // [RULE20]
            LINK.conversion_start_n <= 1'b1;
            cnt                     <= PULSE_LEN - 12'h001;
            state                   <= H_HIGH;
          end
        end
        H_HIGH: begin
          // Pulse no longer than power-up time; the device pulse covers the rest.
          if (cnt == '0) begin
            LINK.conversion_start_n <= 1'b0; // [RULE19]
            state                   <= H_WAIT;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        H_WAIT: begin
          if (busy_q && !LINK.busy) begin
            LINK.chip_select_n <= 1'b0; // [RULE16]
            LINK.read_strobe_n <= 1'b0;
            cnt                <= RD_LEN;
            state              <= H_RD1;
          end else if (LINK.busy && !apd) begin
            LINK.conversion_start_n <= 1'b1; // [RULE8]
          end
        end
        H_RD1, H_RD2: begin
          if (cnt == '0) begin
            LINK.chip_select_n <= 1'b1;
            LINK.read_strobe_n <= 1'b1;
            if (state == H_RD1) begin
              upper <= LINK.data_out; // [RULE13]
            end else begin
              RESULT_OUT <= {upper, LINK.data_out[7:6]};
            end
            if (state == H_RD1 && BYTE_ONLY_IN) begin
              RESULT_OUT <= {LINK.data_out, 2'h0};
            end
            cnt   <= GAP_LEN;
            state <= (state == H_RD1 && !BYTE_ONLY_IN) ? H_SEP : H_GAP;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        H_SEP: begin
          // One released cycle between strobes lets the device see the first read end.
          LINK.chip_select_n <= 1'b0;
          LINK.read_strobe_n <= 1'b0;
          cnt                <= RD_LEN;
          state              <= H_RD2;
        end
        H_GAP: begin
          // Waiting here keeps the next start clear of the read and spaces conversions.
          if (cnt == '0) begin
            DONE_OUT <= 1'b1; // [RULE11] [RULE17]
            state    <= H_IDLE;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end
endmodule

//--- dv/sac_link_properties.sv
// Concurrent checks on the link between the host and device ends.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module sac_link_checker #(
  parameter int CONV_CYCLES = 8
) (
  // Clock and reset.
  input wire logic       CLOCK_IN,
  input wire logic       RST_IN,
  // Link.
  input wire logic       conversion_start_n,
  input wire logic       busy,
  input wire logic       chip_select_n,
  input wire logic       read_strobe_n,
  input wire logic [7:0] data_out,
  input wire logic       data_oe
);
  logic [7:0] since_rise;
  logic [7:0] since_read;
  logic [7:0] busy_len;
  logic       start_q;
  logic       sel_q;
  logic       second;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // The since_rise and since_read counters saturate so that long idle spans never wrap into a false pass.
  always_ff @(posedge CLOCK_IN) begin
    start_q <= conversion_start_n;
    sel_q <= !chip_select_n && !read_strobe_n;
    busy_len <= busy ? busy_len + 8'h01 : 8'h00;
    if (RST_IN || (conversion_start_n && !start_q)) since_rise <= 8'h00;
    else if (since_rise != 8'hFF) since_rise <= since_rise + 8'h01;
    if (RST_IN) since_read <= 8'hFF;
    else if (sel_q && read_strobe_n) since_read <= 8'h00;
    else if (since_read != 8'hFF) since_read <= since_read + 8'h01;
    if (RST_IN || $rose(busy)) second <= 1'b0;
    else if (sel_q && !(!chip_select_n && !read_strobe_n)) second <= !second;
  end
  sequence read_sel;
    !chip_select_n && !read_strobe_n;
  endsequence
  sequence late_start_fall;
    $fell(conversion_start_n) && since_rise >= 8'h82 && !busy;
  endsequence
  drive_when_sel_a: assert property (read_sel |=> data_oe)
    else $error("data bus not driven during read");
  bus_release_a: assert property ((chip_select_n || read_strobe_n) |=> !data_oe)
    else $error("data bus driven outside read");
  busy_length_a: assert property ($fell(busy) |-> busy_len == 8'(CONV_CYCLES))
    else $error("busy length wrong");
  powerup_first_a: assert property ($rose(busy) |-> since_rise >= 8'h7D)
    else $error("conversion began inside power-up pulse");
  start_low_conv_a: assert property ($rose(busy) |-> !conversion_start_n)
    else $error("conversion began with start high");
  fall_starts_a: assert property (late_start_fall |-> ##[1:4] $rose(busy))
    else $error("start fall did not begin conversion");
  low_bits_zero_a: assert property (data_oe && second |-> data_out[5:0] == 6'h00)
    else $error("second read low lines not zero");
  no_read_busy_a: assert property (busy |-> read_strobe_n)
    else $error("read during conversion");
  read_gap_a: assert property ($fell(conversion_start_n) |-> since_read >= 8'h0D)
    else $error("start fell too soon after read");
endmodule

//--- dv/tb_sar_adc_convert_and_read_control.sv
// Self-checking bench: host and device ends joined by the link interface.
// Assumes a shortened conversion count; expectations come from applied codes.
`timescale 1ns/10ps
module tb_sar_adc_convert_and_read_control;
  import sac_pkg::*;
  localparam int CONV = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        req = 1'b0;
  logic        auto = 1'b0;
  logic        byte_only = 1'b0;
  sac_result_t code = '0;
  logic        done, ready, powered, tracking, fast;
  sac_result_t result;
  logic [10:0] expq[$];
  logic [10:0] e;
  logic        second = 1'b0;
  logic        busy_q = 1'b0;
  logic        oe_q = 1'b0;
  int          miscompares = 0;
  int          checks = 0;
  sac_if sac_if_i();
  sac_device #(.CONV_CYCLES(CONV)) sac_device_i (.CLOCK_IN(clk), .RST_IN(rst),
    .SAMPLE_CODE_IN(code), .LINK(sac_if_i), .POWERED_OUT(powered),
    .TRACKING_OUT(tracking), .FAST_MODE_OUT(fast));
  sac_host sac_host_i (.CLOCK_IN(clk), .RST_IN(rst), .REQ_IN(req),
    .AUTO_POWER_DOWN_IN(auto), .BYTE_ONLY_IN(byte_only), .LINK(sac_if_i),
    .DONE_OUT(done), .RESULT_OUT(result), .READY_OUT(ready));
  sac_link_checker #(.CONV_CYCLES(CONV)) sac_link_checker_i (.CLOCK_IN(clk),
    .RST_IN(rst), .conversion_start_n(sac_if_i.conversion_start_n),
    .busy(sac_if_i.busy), .chip_select_n(sac_if_i.chip_select_n),
    .read_strobe_n(sac_if_i.read_strobe_n), .data_out(sac_if_i.data_out),
    .data_oe(sac_if_i.data_oe));
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  // The monitor samples at the edge, so it sees settled values of the prior cycle.
  always @(posedge clk) begin
    busy_q <= sac_if_i.busy;
    oe_q <= sac_if_i.data_oe;
    if (sac_if_i.busy === 1'b1 && !busy_q) second <= 1'b0;
    else if (oe_q === 1'b1 && sac_if_i.data_oe === 1'b0) second <= !second;
    if (sac_if_i.data_oe === 1'b1 && expq.size() > 0) begin
      e = expq[0];
      check("data", 10'(sac_if_i.data_out),
            10'(second ? {e[1:0], 6'h00} : e[9:2]));
    end
    if (done === 1'b1) begin
      if (expq.size() == 0) check("spare done", 10'h001, 10'h000);
      else begin
        e = expq.pop_front();
        check("result", result, e[9:0]);
        check("fast mode", 10'(fast), 10'(!e[10]));
        check("powered", 10'(powered), 10'(!e[10]));
        check("tracking", 10'(tracking), 10'h001);
      end
    end
  end
  initial begin
    int k;
    logic [31:0] r;
    logic [9:0] c;
    void'($urandom(7586));
    repeat (6) @(posedge clk);
    check("powered at reset", 10'(powered), 10'h000);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      r = $urandom;
      c = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : r[9:0];
      k = 0;
      while (ready !== 1'b1 && k < 2000) begin
        @(posedge clk);
        k++;
      end
      if (k == 2000) miscompares++;
      @(posedge clk);
      req <= 1'b1;
      auto <= i[0];
      byte_only <= i[1];
      code <= c;
      expq.push_back({i[0], i[1] ? {c[9:2], 2'h0} : c});
      @(posedge clk);
      req <= 1'b0;
      k = 0;
      while (expq.size() != 0 && k < 2000) begin
        @(posedge clk);
        k++;
      end
      if (k == 2000) miscompares++;
    end
    tally_and_finish();
  end
endmodule
